// >>> atc_conv_model.sv
// Behavioural converter that answers the core's conversion starts.
// Assumes one-cycle start pulses on the core clock.
`timescale 1ns/1ps
module atc_conv_model (
  // Clock and handshake.
  input wire logic clk,
  input wire logic start,
  output logic done,
  output logic [11:0] data
);
  int n = 0;
  int wait_c = 0;
  initial begin
    done = 1'b0;
    data = 12'h000;
  end
  // The data bus toggles when no sample is offered, so a stale read shows.
  always @(posedge clk) begin
    done <= 1'b0;
    data <= ~data;
    if (start) begin
      wait_c <= 2;
    end else if (wait_c == 1) begin
      done <= 1'b1;
      data <= 12'hA5C ^ 12'(n * 37);
      n <= n + 1;
      wait_c <= 0;
    end else if (wait_c > 1) begin
      wait_c <= wait_c - 1;
    end
  end
endmodule

// >>> atc_core.sv
// Conversion start timing, averaging, channel I/O and check codes.
// Assumes an outside serial engine that decodes frames into the strobes here.
`timescale 1ns/1ps
module atc_core #(
  parameter int BASE_UNIT_Q = atc_pkg::BASE_Q,
  parameter int TURBO_UNIT_Q = atc_pkg::TURBO_Q
) (
  // Clock and reset.
  input logic CLK,
  input logic RST_N,
  // Mode and configuration.
  input logic [1:0] MODE,
  input logic [2:0] MAN_CH,
  input logic CFG_WR,
  input logic [7:0] CFG_PIN_FUNCTION,
  input logic [7:0] CFG_DIRECTION,
  input logic [7:0] CFG_DRIVE_TYPE,
  input logic [7:0] CFG_AUTOSEQ,
  input logic [2:0] CFG_AVERAGE_FACTOR,
  input logic [3:0] CFG_RATE_DIVIDER,
  input logic CFG_OSC_SELECT,
  // Conversion requests and status.
  input logic I2C_CONV_REQ,
  input logic CONVERT_START_BIT,
  input logic STATS_ENABLE,
  input logic AVG_DONE_CLR,
  output logic AVERAGE_DONE,
  // Converter handshake.
  output logic CONV_START,
  output logic [2:0] CONV_CH,
  input logic CONV_DONE,
  input logic [11:0] CONV_DATA,
  // Results.
  output logic AVG_VALID,
  output logic [15:0] AVG_RESULT,
  output logic [2:0] AVG_CH,
  output logic CMP_VALID,
  output logic [11:0] CMP_DATA,
  input logic [2:0] RES_RD_CH,
  output logic [15:0] LATEST_RESULT,
  // Channel pins and levels.
  input logic OUTPUT_LEVEL_WR,
  input logic [7:0] OUTPUT_LEVEL_DATA,
  input logic [7:0] EVENT_FLAGS,
  input logic [7:0] EVENT_TRIG_EN,
  input logic [7:0] EVENT_TRIG_LEVEL,
  input logic [7:0] GPIO_IN,
  output logic [7:0] GPIO_OUT,
  output logic [7:0] GPIO_OE,
  output logic [7:0] INPUT_LEVEL,
  output logic [7:0] OUTPUT_LEVEL,
  // Serial clock pin.
  input logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  // Check codes.
  input logic CHECK_CODE_ENABLE,
  input logic RX_DATA_VALID,
  input logic [7:0] RX_DATA,
  input logic RX_CRC_VALID,
  input logic [7:0] RX_CRC,
  input logic CRC_ERR_CLR,
  output logic RX_ACCEPT,
  output logic RX_REJECT,
  output logic CRC_IN_ERROR,
  input logic TX_VALID,
  input logic [7:0] TX_DATA,
  output logic TX_CRC_VALID,
  output logic [7:0] TX_CRC
);
  import atc_pkg::*;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Pin synchronisers.
  logic [7:0] gpio_s1;
  logic scl_s1;
  logic scl_s2;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      gpio_s1 <= 8'h00;
      INPUT_LEVEL <= 8'h00;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
    end else begin
      gpio_s1 <= GPIO_IN;
      INPUT_LEVEL <= gpio_s1;
      scl_s1 <= SCL_IN;
      scl_s2 <= scl_s1;
    end
  end

  // Configuration; writes are held off while a check error stands.
  logic [7:0] pin_function, direction, drive_type, autoseq;
  logic [2:0] average_factor;
  logic [3:0] rate_divider;
  logic oscillator_select;
  logic cfg_take;
  assign cfg_take = CFG_WR && !CRC_IN_ERROR;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_function <= PIN_RST;
      direction <= PIN_RST;
      drive_type <= PIN_RST;
      autoseq <= PIN_RST;
      average_factor <= AVG_RST;
      rate_divider <= DIV_RST;
      oscillator_select <= 1'b0;
    end else if (cfg_take) begin
      pin_function <= CFG_PIN_FUNCTION;
      direction <= CFG_DIRECTION;
      drive_type <= CFG_DRIVE_TYPE;
      autoseq <= CFG_AUTOSEQ;
      average_factor <= CFG_AVERAGE_FACTOR;
      rate_divider <= CFG_RATE_DIVIDER;
      oscillator_select <= CFG_OSC_SELECT;
    end
  end

  // Output levels and pin drivers.
  logic [7:0] next_level, next_out, next_oe, dout_en, flags_q, evt_rise;
  assign evt_rise = EVENT_FLAGS & ~flags_q & EVENT_TRIG_EN;
  always_comb begin
    next_level = OUTPUT_LEVEL;
    if (OUTPUT_LEVEL_WR && !CRC_IN_ERROR) begin
      next_level = OUTPUT_LEVEL_DATA;
    end
    next_level = (next_level & ~evt_rise) |
      (EVENT_TRIG_LEVEL & evt_rise);
  end
  for (genvar g = 0; g < 8; g++) begin : g_pin
    assign dout_en[g] = pin_function[g] & direction[g];
    // Open-drain only pulls low; a one is left to the pull-up.
    assign next_oe[g] = dout_en[g] & (drive_type[g] | ~OUTPUT_LEVEL[g]);
    assign next_out[g] = OUTPUT_LEVEL[g];
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      OUTPUT_LEVEL <= LEVEL_RST;
      flags_q <= 8'h00;
      GPIO_OUT <= 8'h00;
      GPIO_OE <= 8'h00;
    end else begin
      OUTPUT_LEVEL <= next_level;
      flags_q <= EVENT_FLAGS;
      GPIO_OUT <= next_out;
      GPIO_OE <= next_oe;
    end
  end

  // Start-rate generator: quarter-cycle accumulator, so 62.5 cycles works.
  logic [ACC_W-1:0] acc, next_acc, acc_sum, period;
  logic tick, tick_pend, next_tick_pend, acc_clr, next_start;
  always_comb begin
    period = ACC_W'((MODE == MODE_TURBO ? TURBO_UNIT_Q : BASE_UNIT_Q)
      * int'(atc_mult2(rate_divider))
      * (oscillator_select ? OSC1_SCALE : 1));
    acc_sum = acc + Q_STEP;
    tick = !acc_clr && (acc_sum >= period);
    if (acc_clr) begin
      next_acc = '0;
    end else if (tick) begin
      next_acc = acc_sum - period;
    end else begin
      next_acc = acc_sum;
    end
    next_tick_pend = !acc_clr && (tick || tick_pend) && !next_start;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      acc <= '0;
      tick_pend <= 1'b0;
    end else begin
      acc <= next_acc;
      tick_pend <= next_tick_pend;
    end
  end

  // Conversion sequencer and averaging.
  atc_state_t state, next_state;
  logic [1:0] run_mode, next_run_mode;
  logic [2:0] next_ch, seek, base;
  logic [7:0] cnt, next_cnt, nsamp, amask;
  logic [SUM_W-1:0] sum, next_sum;
  logic [SUM_W+3:0] wide;
  logic stretch_pend, next_stretch, stats_pend, next_stats;
  logic next_done, next_avg_valid, next_scl_oe, fin;
  logic [15:0] next_avg;
  logic [2:0] idx;

  assign amask = autoseq & ~pin_function;
  assign nsamp = 8'h01 << average_factor;

  always_comb begin
    base = (state == ST_IDLE) ? 3'h7 : CONV_CH;
    seek = base;
    idx = 3'h0;
    for (int k = 1; k <= 8; k++) begin
      idx = base + 3'(k);
      if (amask[idx] && seek == base) begin
        seek = idx;
      end
    end
  end

  always_comb begin
    next_state = state;
    next_run_mode = run_mode;
    next_ch = CONV_CH;
    next_cnt = cnt;
    next_sum = sum;
    next_start = 1'b0;
    next_stretch = stretch_pend;
    next_stats = stats_pend;
    next_done = AVERAGE_DONE;
    next_avg_valid = 1'b0;
    next_avg = AVG_RESULT;
    wide = '0;
    acc_clr = 1'b0;
    fin = 1'b0;
    if (AVG_DONE_CLR) begin
      next_done = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        acc_clr = 1'b1;
        next_cnt = 8'h00;
        next_sum = '0;
        next_run_mode = MODE;
        if (MODE == MODE_TURBO) begin
          next_ch = MAN_CH;
          next_state = ST_WAIT;
        end else if (MODE == MODE_AUTO && |amask) begin
          next_ch = seek;
          next_state = ST_WAIT;
        end else if (MODE == MODE_MANUAL && (I2C_CONV_REQ ||
                     (CONVERT_START_BIT && STATS_ENABLE))) begin
          next_ch = MAN_CH;
          next_start = 1'b1;
          next_state = ST_CONV;
          next_stretch = I2C_CONV_REQ;
          next_stats = !I2C_CONV_REQ;
        end
      end
      ST_WAIT: begin
        if (MODE != run_mode) begin
          next_state = ST_IDLE;
          next_stretch = 1'b0;
          next_stats = 1'b0;
        end else if (tick || tick_pend) begin
          next_start = 1'b1;
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (CONV_DONE) begin
          next_sum = sum + SUM_W'(CONV_DATA);
          next_cnt = cnt + 8'h01;
          fin = (run_mode == MODE_TURBO) || (next_cnt == nsamp);
          if (fin) begin
            wide = {next_sum, 4'h0} >> (run_mode == MODE_TURBO ?
              3'h0 : average_factor);
            next_avg = wide[15:0];
            next_avg_valid = 1'b1;
            next_cnt = 8'h00;
            next_sum = '0;
            next_stretch = 1'b0;
            next_stats = 1'b0;
            if (stats_pend) begin
              next_done = 1'b1;
            end
            if (run_mode == MODE_MANUAL) begin
              next_state = ST_IDLE;
            end else begin
              next_state = ST_WAIT;
            end
            if (run_mode == MODE_AUTO) begin
              next_ch = seek;
            end
          end else begin
            next_state = ST_WAIT;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Stretch only once the host has pulled the clock low itself.
    next_scl_oe = next_stretch && (SCL_OE || !scl_s2);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      run_mode <= MODE_MANUAL;
      CONV_CH <= 3'h0;
      cnt <= 8'h00;
      sum <= '0;
      CONV_START <= 1'b0;
      stretch_pend <= 1'b0;
      stats_pend <= 1'b0;
      AVERAGE_DONE <= 1'b0;
      AVG_VALID <= 1'b0;
      AVG_RESULT <= 16'h0000;
      AVG_CH <= 3'h0;
      CMP_VALID <= 1'b0;
      CMP_DATA <= 12'h000;
      SCL_OE <= 1'b0;
    end else begin
      state <= next_state;
      run_mode <= next_run_mode;
      CONV_CH <= next_ch;
      cnt <= next_cnt;
      sum <= next_sum;
      CONV_START <= next_start;
      stretch_pend <= next_stretch;
      stats_pend <= next_stats;
      AVERAGE_DONE <= next_done;
      AVG_VALID <= next_avg_valid;
      AVG_RESULT <= next_avg;
      if (next_avg_valid) begin
        AVG_CH <= CONV_CH;
      end
      CMP_VALID <= next_avg_valid;
      CMP_DATA <= next_avg[15:4];
      SCL_OE <= next_scl_oe;
    end
  end
  assign SCL_OUT = 1'b0;

  atc_result_mem u_mem (
    .clk(CLK),
    .rst_n(RST_N),
    .we(AVG_VALID),
    .waddr(AVG_CH),
    .wdata(AVG_RESULT),
    .raddr(RES_RD_CH),
    .rdata(LATEST_RESULT)
  );

  // Check codes on received and sent bytes.
  logic [7:0] exp_crc, next_exp, next_tx_crc;
  logic have_data, next_have, next_err, next_acc_ok, next_rej, next_txv;
  always_comb begin
    next_exp = exp_crc;
    next_have = have_data;
    next_acc_ok = 1'b0;
    next_rej = 1'b0;
    next_err = CRC_IN_ERROR;
    if (CRC_ERR_CLR) begin
      next_err = 1'b0;
    end
    if (!CHECK_CODE_ENABLE) begin
      next_acc_ok = RX_DATA_VALID;
      next_have = 1'b0;
    end else if (RX_DATA_VALID) begin
      next_exp = atc_crc8(RX_DATA);
      next_have = 1'b1;
    end else if (RX_CRC_VALID && have_data) begin
      next_have = 1'b0;
      if (RX_CRC == exp_crc) begin
        next_acc_ok = 1'b1;
      end else begin
        next_rej = 1'b1;
        next_err = 1'b1;
      end
    end
    next_txv = TX_VALID && CHECK_CODE_ENABLE;
    next_tx_crc = TX_VALID ? atc_crc8(TX_DATA) : TX_CRC;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      exp_crc <= CRC_INIT;
      have_data <= 1'b0;
      RX_ACCEPT <= 1'b0;
      RX_REJECT <= 1'b0;
      CRC_IN_ERROR <= 1'b0;
      TX_CRC_VALID <= 1'b0;
      TX_CRC <= CRC_INIT;
    end else begin
      exp_crc <= next_exp;
      have_data <= next_have;
      RX_ACCEPT <= next_acc_ok;
      RX_REJECT <= next_rej;
      CRC_IN_ERROR <= next_err;
      TX_CRC_VALID <= next_txv;
      TX_CRC <= next_tx_crc;
    end
  end

  // Helper: cycles between start-rate ticks.
  logic [ACC_W-1:0] gap;
  logic gap_ok;
  always_ff @(posedge CLK) begin
    if (!RST_N || acc_clr || CFG_WR) begin
      gap <= 24'h000001;
      gap_ok <= 1'b0;
    end else begin
      gap <= tick ? 24'h000001 : gap + 24'h000001;
      gap_ok <= gap_ok || tick;
    end
  end

  a_tick_spacing: assert property (tick && gap_ok |->
    ({gap, 2'b00} + 26'h4 > {2'b00, period}) &&
    ({gap, 2'b00} < {2'b00, period} + 26'h4))
    else $error("start tick spacing off the selected cycle");
  a_host_first: assert property (state == ST_IDLE &&
    MODE == MODE_MANUAL && I2C_CONV_REQ |=> CONV_START && state == ST_CONV)
    else $error("host request did not start a conversion");
  a_tick_start: assert property (CONV_START &&
    $past(state) == ST_WAIT |-> $past(tick) || $past(tick_pend))
    else $error("internal start without a rate tick");
  a_stretch_hold: assert property (SCL_OE && stretch_pend && !fin
    |=> SCL_OE)
    else $error("clock released before averaging finished");
  a_stretch_end: assert property (fin |-> ##2 !SCL_OE)
    else $error("clock still held after averaging");
  a_done_flag: assert property (fin && stats_pend |=> AVERAGE_DONE[*2])
    else $error("average done not raised");
  a_cmp_top: assert property (CMP_VALID |->
    CMP_DATA == AVG_RESULT[15:4])
    else $error("comparator data not top bits of average");
  a_pp_drive: assert property (1 |=>
    (GPIO_OE & $past(dout_en & drive_type)) == $past(dout_en & drive_type))
    else $error("push-pull output not driven");
  a_crc_block: assert property (CRC_IN_ERROR && CFG_WR |=>
    $stable(pin_function) && $stable(rate_divider))
    else $error("configuration written during check error");
  a_crc_flag: assert property (RX_REJECT |-> CRC_IN_ERROR)
    else $error("mismatch without error flag");
  a_tx_code: assert property (TX_VALID && CHECK_CODE_ENABLE |=>
    TX_CRC_VALID && TX_CRC == atc_crc8($past(TX_DATA)))
    else $error("sent byte lacks its check byte");
  a_no_check: assert property (!CHECK_CODE_ENABLE |=>
    !TX_CRC_VALID && !RX_REJECT)
    else $error("check logic active while disabled");

  c_avg_stretch: cover property (I2C_CONV_REQ && state == ST_IDLE ##[1:1000]
    fin ##2 !SCL_OE);
  c_stats_done: cover property (fin && stats_pend);
  c_crc_error: cover property (RX_REJECT);
  c_auto_walk: cover property (run_mode == MODE_AUTO && AVG_VALID &&
    AVG_CH != 3'h0);
endmodule

// >>> atc_pkg.sv
// Shared constants, types and helpers for the converter control core.
// Assumes a 200 MHz core clock; all timing counts derive from CLK_PERIOD_PS.
package atc_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // Half of the base start cycle, so that the x1.5 steps stay whole.
  localparam int BASE_HALF_PS = 500000;
  localparam int TURBO_HALF_PS = 156250;
  // Quarter clock cycles per half base cycle; turbo needs the quarters.
  localparam int BASE_Q = BASE_HALF_PS * 4 / CLK_PERIOD_PS;
  localparam int TURBO_Q = TURBO_HALF_PS * 4 / CLK_PERIOD_PS;
  localparam int OSC1_SCALE = 32;
  localparam int ACC_W = 24;
  localparam logic [ACC_W-1:0] Q_STEP = 24'h000004;
  localparam int SUM_W = 19;

  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_TURBO = 2'h2;

  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [2:0] AVG_RST = 3'h0;
  localparam logic [3:0] DIV_RST = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } atc_state_t;

  // Cycle multiplier times two: 2,3,4,6,8,12 ... 384.
  function automatic logic [8:0] atc_mult2(input logic [3:0] code);
    logic [8:0] m;
    m = code[0] ? 9'h003 : 9'h002;
    return m << code[3:1];
  endfunction

  // Check byte of one data byte, most significant bit first.
  function automatic logic [7:0] atc_crc8(input logic [7:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage

// >>> atc_result_mem.sv
// Eight-entry store of the latest 16-bit result of each channel.
// Assumes one write and one read port on the core clock; read data registered.
`timescale 1ns/1ps
module atc_result_mem (
  // Clock and reset.
  input logic clk,
  input logic rst_n,
  // Write port.
  input logic we,
  input logic [2:0] waddr,
  input logic [15:0] wdata,
  // Read port.
  input logic [2:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [8];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Entries are not cleared; the read register is, so reset reads zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// >>> test_adc_timing_avg_gpio_crc_ctrl.sv
// Self-checking bench for the converter control core.
// Assumes a 200 MHz core clock and shortened rate units.
`timescale 1ns/1ps
module test_adc_timing_avg_gpio_crc_ctrl;
  import atc_pkg::*;
  // Twelve keeps every start cycle longer than the five-cycle conversion loop.
  localparam int BU = 12;
  localparam int TU = 4;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [1:0] MODE = 2'h0;
  logic [2:0] MAN_CH = 3'h0, CFG_AVERAGE_FACTOR = 3'h0, RES_RD_CH = 3'h0;
  logic [3:0] CFG_RATE_DIVIDER = 4'h0;
  logic CFG_WR = 1'b0, CFG_OSC_SELECT = 1'b0, I2C_CONV_REQ = 1'b0;
  logic CONVERT_START_BIT = 1'b0, STATS_ENABLE = 1'b0, AVG_DONE_CLR = 1'b0;
  logic OUTPUT_LEVEL_WR = 1'b0, SCL_IN = 1'b1, CHECK_CODE_ENABLE = 1'b0;
  logic RX_DATA_VALID = 1'b0, RX_CRC_VALID = 1'b0, CRC_ERR_CLR = 1'b0;
  logic TX_VALID = 1'b0;
  logic [7:0] CFG_PIN_FUNCTION = 8'h00, CFG_DIRECTION = 8'h00;
  logic [7:0] CFG_DRIVE_TYPE = 8'h00, CFG_AUTOSEQ = 8'h00;
  logic [7:0] OUTPUT_LEVEL_DATA = 8'h00, EVENT_FLAGS = 8'h00;
  logic [7:0] EVENT_TRIG_EN = 8'h00, EVENT_TRIG_LEVEL = 8'h00, ext = 8'h00;
  logic [7:0] RX_DATA = 8'h00, RX_CRC = 8'h00, TX_DATA = 8'h00, GPIO_IN;
  logic AVERAGE_DONE, CONV_START, CONV_DONE, AVG_VALID, CMP_VALID, SCL_OUT;
  logic SCL_OE, RX_ACCEPT, RX_REJECT, CRC_IN_ERROR, TX_CRC_VALID;
  logic [2:0] CONV_CH, AVG_CH;
  logic [11:0] CONV_DATA, CMP_DATA;
  logic [15:0] AVG_RESULT, LATEST_RESULT, last_res, ex;
  logic [7:0] GPIO_OUT, GPIO_OE, INPUT_LEVEL, OUTPUT_LEVEL, TX_CRC;
  logic [31:0] rs = 32'h00002EFC;
  int err_count = 0, check_count = 0, fac = 0, exp_gap = 0, gap = 0;
  int sum = 0, nsamp = 0;
  bit have_prev = 0;
  logic [2:0] exp_ch[$];
  int mul2[16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192,
                   256, 384};
  int cd[6] = '{0, 1, 5, 0, 3, 0};
  int os[6] = '{0, 0, 0, 1, 0, 1};

  // A pin shows what the core drives, else what the board puts on it.
  assign GPIO_IN = (GPIO_OE & GPIO_OUT) | (~GPIO_OE & ext);

  atc_core #(.BASE_UNIT_Q(BU), .TURBO_UNIT_Q(TU)) atc_core_i (
    .CLK, .RST_N, .MODE, .MAN_CH, .CFG_WR, .CFG_PIN_FUNCTION, .CFG_DIRECTION,
    .CFG_DRIVE_TYPE, .CFG_AUTOSEQ, .CFG_AVERAGE_FACTOR, .CFG_RATE_DIVIDER,
    .CFG_OSC_SELECT, .I2C_CONV_REQ, .CONVERT_START_BIT, .STATS_ENABLE,
    .AVG_DONE_CLR, .AVERAGE_DONE, .CONV_START, .CONV_CH, .CONV_DONE,
    .CONV_DATA, .AVG_VALID, .AVG_RESULT, .AVG_CH, .CMP_VALID, .CMP_DATA,
    .RES_RD_CH, .LATEST_RESULT, .OUTPUT_LEVEL_WR, .OUTPUT_LEVEL_DATA,
    .EVENT_FLAGS, .EVENT_TRIG_EN, .EVENT_TRIG_LEVEL, .GPIO_IN, .GPIO_OUT,
    .GPIO_OE, .INPUT_LEVEL, .OUTPUT_LEVEL, .SCL_IN, .SCL_OUT, .SCL_OE,
    .CHECK_CODE_ENABLE, .RX_DATA_VALID, .RX_DATA, .RX_CRC_VALID, .RX_CRC,
    .CRC_ERR_CLR, .RX_ACCEPT, .RX_REJECT, .CRC_IN_ERROR, .TX_VALID, .TX_DATA,
    .TX_CRC_VALID, .TX_CRC
  );
  atc_conv_model atc_conv_model_i (.clk(CLK), .start(CONV_START),
    .done(CONV_DONE), .data(CONV_DATA));

  always #2.5 CLK = ~CLK;

  task automatic chk(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction

  // Long division by the nine-bit pattern, remainder starting from zero.
  function automatic logic [7:0] crc(input logic [7:0] d);
    logic [15:0] r;
    r = {d, 8'h00};
    for (int i = 15; i >= 8; i--) begin
      if (r[i]) r = r ^ (16'h0107 << (i - 8));
    end
    return r[7:0];
  endfunction

  function automatic int gapf(input int u, input int c, input int o);
    return u * mul2[c] * (o ? 32 : 1) / 4;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic cfg(input logic [7:0] pf, dir, drv, seq,
                     input logic [2:0] f, input logic [3:0] dv, input logic o);
    @(posedge CLK);
    CFG_PIN_FUNCTION <= pf;
    CFG_DIRECTION <= dir;
    CFG_DRIVE_TYPE <= drv;
    CFG_AUTOSEQ <= seq;
    CFG_AVERAGE_FACTOR <= f;
    CFG_RATE_DIVIDER <= dv;
    CFG_OSC_SELECT <= o;
    CFG_WR <= 1'b1;
    @(posedge CLK);
    CFG_WR <= 1'b0;
    fac = f;
  endtask

  task automatic lvl(input logic [7:0] d);
    @(posedge CLK);
    OUTPUT_LEVEL_WR <= 1'b1;
    OUTPUT_LEVEL_DATA <= d;
    @(posedge CLK);
    OUTPUT_LEVEL_WR <= 1'b0;
  endtask

  task automatic start(input bit i2c);
    @(posedge CLK);
    if (i2c) I2C_CONV_REQ <= 1'b1;
    else CONVERT_START_BIT <= 1'b1;
    @(posedge CLK);
    I2C_CONV_REQ <= 1'b0;
    CONVERT_START_BIT <= 1'b0;
  endtask

  task automatic wait_avg();
    int k;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (AVG_VALID !== 1'b1 && k < 3000);
    chk("result wait", 16'(k < 3000), 16'h0001);
  endtask

  task automatic rx(input logic [7:0] d, c, input bit ok);
    @(posedge CLK);
    RX_DATA_VALID <= 1'b1;
    RX_DATA <= d;
    @(posedge CLK);
    RX_DATA_VALID <= 1'b0;
    RX_CRC_VALID <= 1'b1;
    RX_CRC <= c;
    @(posedge CLK);
    RX_CRC_VALID <= 1'b0;
    #1;
    chk("rx accept", 16'(RX_ACCEPT), 16'(ok));
    chk("rx reject", 16'(RX_REJECT), 16'(!ok));
  endtask

  task automatic tx(input logic [7:0] d);
    @(posedge CLK);
    TX_VALID <= 1'b1;
    TX_DATA <= d;
    @(posedge CLK);
    TX_VALID <= 1'b0;
    #1;
    chk("tx valid", 16'(TX_CRC_VALID), 16'(CHECK_CODE_ENABLE));
    if (CHECK_CODE_ENABLE) chk("tx byte", 16'(TX_CRC), 16'(crc(d)));
  endtask

  // Reference model: sums samples, checks spacing and every result.
  always @(posedge CLK) begin
    gap++;
    if (CONV_START === 1'b1) begin
      if (have_prev && exp_gap > 0) chk("gap", 16'(gap), 16'(exp_gap));
      have_prev = 1;
      gap = 0;
    end
    if (CONV_DONE === 1'b1) begin
      sum += CONV_DATA;
      nsamp++;
    end
    if (AVG_VALID === 1'b1) begin
      ex = 16'((sum << 4) >> fac);
      last_res = ex;
      chk("average", AVG_RESULT, ex);
      chk("compare", 16'(CMP_DATA), 16'(ex[15:4]));
      chk("samples", 16'(nsamp), 16'(1 << fac));
      chk("cmp valid", 16'(CMP_VALID), 16'h0001);
      if (exp_ch.size() > 0) begin
        chk("channel", 16'(AVG_CH), 16'(exp_ch.pop_front()));
      end
      sum = 0;
      nsamp = 0;
    end
  end

  initial begin
    #400000;
    err_count++;
    $display("ERROR watchdog expired");
    final_report();
  end

  initial begin
    logic [7:0] pf, dir, drv, lv, oe;
    logic [2:0] ch;
    cyc(3);
    RST_N <= 1'b1;
    cyc(3);
    chk("oe reset", 16'(GPIO_OE), 16'h0000);
    chk("level reset", 16'(OUTPUT_LEVEL), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      pf = rnd();
      dir = rnd();
      drv = rnd();
      lv = rnd();
      // Released open-drain pins float up to the board's pull-up.
      ext <= rnd() | (pf & dir & ~drv);
      cfg(pf, dir, drv, 8'h00, 3'h0, 4'h0, 1'b0);
      lvl(lv);
      cyc(5);
      oe = pf & dir & (drv | ~lv);
      chk("output level", 16'(OUTPUT_LEVEL), 16'(lv));
      chk("pin enable", 16'(GPIO_OE), 16'(oe));
      chk("pin drive", 16'(GPIO_OUT & oe), 16'(lv & oe));
      chk("input", 16'(INPUT_LEVEL), 16'((oe & lv) | (~oe & ext)));
    end
    cfg(8'hFF, 8'hFF, 8'hFF, 8'h00, 3'h0, 4'h0, 1'b0);
    lvl(8'h00);
    EVENT_TRIG_EN <= 8'h81;
    EVENT_TRIG_LEVEL <= 8'h81;
    cyc(1);
    EVENT_FLAGS <= 8'h83;
    cyc(4);
    chk("event level", 16'(OUTPUT_LEVEL), 16'h0081);
    STATS_ENABLE <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg(8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 4'(cd[i]), os[i][0]);
      exp_gap = gapf(BU, cd[i], os[i]);
      ch = 3'(rnd());
      MAN_CH <= ch;
      RES_RD_CH <= ch;
      exp_ch.push_back(ch);
      have_prev = 0;
      start(1'b0);
      wait_avg();
      cyc(3);
      chk("avg done", 16'(AVERAGE_DONE), 16'h0001);
      chk("latest", LATEST_RESULT, last_res);
      chk("no stretch", 16'(SCL_OE), 16'h0000);
      AVG_DONE_CLR <= 1'b1;
      cyc(1);
      AVG_DONE_CLR <= 1'b0;
    end
    STATS_ENABLE <= 1'b0;
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 4'h2, 1'b0);
    exp_gap = gapf(BU, 2, 0);
    have_prev = 0;
    exp_ch.push_back(ch);
    repeat (9) begin
      #40;
      SCL_IN <= ~SCL_IN;
    end
    start(1'b1);
    cyc(12);
    chk("stretch", 16'(SCL_OE), 16'h0001);
    chk("stretch low", 16'(SCL_OUT), 16'h0000);
    wait_avg();
    cyc(3);
    chk("release", 16'(SCL_OE), 16'h0000);
    SCL_IN <= 1'b1;
    for (int i = 4; i < 6; i++) begin
      cfg(8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 4'(cd[i]), os[i][0]);
      exp_gap = gapf(TU, cd[i], os[i]);
      have_prev = 0;
      repeat (4) exp_ch.push_back(ch);
      MODE <= MODE_TURBO;
      repeat (4) wait_avg();
      MODE <= MODE_MANUAL;
      exp_gap = 0;
      cyc(300);
      exp_ch.delete();
    end
    cfg(8'h02, 8'h00, 8'h00, 8'h26, 3'h1, 4'h0, 1'b0);
    exp_gap = gapf(BU, 0, 0);
    have_prev = 0;
    exp_ch = '{3'h2, 3'h5, 3'h2, 3'h5};
    MODE <= MODE_AUTO;
    repeat (4) wait_avg();
    MODE <= MODE_MANUAL;
    exp_gap = 0;
    cyc(50);
    exp_ch.delete();
    CHECK_CODE_ENABLE <= 1'b1;
    tx(8'h00);
    for (int i = 0; i < 4; i++) begin
      lv = rnd();
      tx(lv);
      rx(lv, crc(lv) ^ {7'h00, i == 3}, i != 3);
    end
    chk("error flag", 16'(CRC_IN_ERROR), 16'h0001);
    cfg(8'hFF, 8'hFF, 8'hFF, 8'h00, 3'h0, 4'h0, 1'b0);
    lvl(8'h00);
    cyc(3);
    chk("blocked cfg", 16'(GPIO_OE), 16'h0000);
    chk("blocked lvl", 16'(OUTPUT_LEVEL), 16'h0081);
    CRC_ERR_CLR <= 1'b1;
    cyc(1);
    CRC_ERR_CLR <= 1'b0;
    cfg(8'hFF, 8'hFF, 8'hFF, 8'h00, 3'h0, 4'h0, 1'b0);
    cyc(3);
    chk("open cfg", 16'(GPIO_OE), 16'h00FF);
    CHECK_CODE_ENABLE <= 1'b0;
    tx(rnd());
    final_report();
  end
endmodule
